//--- rtl/din_consts.svh
// Constants of the filtered input port: timing, offsets, fields, resets
`ifndef DIN_CONSTS_SVH
`define DIN_CONSTS_SVH

// Clock and filter times
`define CLK_HZ 40000000
`define FILT_SHORT_US 1000
`define FILT_LONG_US 10000
`define CYC_PER_US (`CLK_HZ / 1000000)
`define SHORT_CYC (`FILT_SHORT_US * `CYC_PER_US)
`define LONG_CYC (`FILT_LONG_US * `CYC_PER_US)
`define FILT_CNT_W 19

// Register byte offsets
`define OFF_POINT 8'h00
`define OFF_CFG 8'h04
`define OFF_STAT 8'h08
`define OFF_MASK 8'h0c

// Field positions
`define CFG_LONG_BIT 0
`define CFG_IRQEN_BIT 1
`define CFG_RISE_BIT 2
`define ST_EDGE_BIT 0
`define ST_CHG_BIT 1

// Reset values
`define CFG_RST 3'h0
`define MASK_RST 2'h0
`define STAT_RST 2'h0

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/din_pkg.sv
// Types of the filtered input port
package din_pkg;

  // Module-wide filter time choice
  typedef enum logic {FILT_1MS, FILT_10MS} filt_sel_t;

  // Active edge of the interrupt capable point
  typedef enum logic {EDGE_FALL, EDGE_RISE} edge_sel_t;

  typedef logic [31:0] word_t;

endpackage

//--- rtl/point_filter.sv
// One input point: three-stage synchroniser and hold-time filter
`timescale 1ns/1ps

module point_filter #(
  parameter int CNT_W = 19
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic raw_in,
  input wire logic [CNT_W-1:0] limit_in,
  output logic stable_out,
  output logic filt_out
);

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic stable_r;
  logic filt_r;
  logic [CNT_W-1:0] cnt_r;
  logic agree_w;
  logic differ_w;
  logic done_w;

  // A level counts once the last two stages agree
  assign agree_w = (sync2_r == sync3_r);
  assign differ_w = (stable_r != filt_r);
  assign done_w = (cnt_r >= (limit_in - CNT_W'(1)));

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser, the first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      stable_r <= 1'b0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (agree_w) begin
        stable_r <= sync3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filtered level follows only after a full hold time
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      filt_r <= 1'b0;
    end else if (!differ_w) begin
      cnt_r <= '0;
    end else if (done_w) begin
      cnt_r <= '0;
      filt_r <= stable_r;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  assign stable_out = stable_r;
  assign filt_out = filt_r;

endmodule

//--- rtl/din_top.sv
// Top of the 32-point filtered input port with edge interrupt and AXI4-Lite
`timescale 1ns/1ps
`include "din_consts.svh"

// How it works
// - Thirty-two points in four groups of eight, all readable by the controller.
// - Input filter delay is either one or ten milliseconds.
// - One filter setting serves every point; no per-point choice.
// - Only the first point of the first group has an edge interrupt; a filtered change of any point can also raise it.
// - A setting picks rising or falling edge for that interrupt.
// - Point 0 edge detection bypasses the filter, same response for both delays; the change source waits for the filter.
// - One status indicator per point shows its filtered ON/OFF state.

module din_top #(
  parameter int SHORT_CYCLES = `SHORT_CYC,
  parameter int LONG_CYCLES = `LONG_CYC,
  parameter int CNT_W = `FILT_CNT_W,
  parameter int ADDR_W = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [31:0] POINT_IN,
  output logic [31:0] LED_OUT,
  output logic IRQ_OUT,
  input wire logic [ADDR_W-1:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [ADDR_W-1:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge write data into a word under byte strobes
  function automatic din_pkg::word_t byte_merge(input din_pkg::word_t old_v,
                                                input din_pkg::word_t new_v,
                                                input logic [3:0] strb);
    din_pkg::word_t res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // True for a mapped register offset
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] a8;
    a8 = 8'(a);
    return (a8 == `OFF_POINT) || (a8 == `OFF_CFG) ||
           (a8 == `OFF_STAT) || (a8 == `OFF_MASK);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  din_pkg::word_t rdata_r;
  logic aw_ok_r;
  logic w_ok_r;
  logic [ADDR_W-1:0] awaddr_r;
  din_pkg::word_t wdata_r;
  logic [3:0] wstrb_r;
  din_pkg::filt_sel_t filt_sel_r;
  din_pkg::edge_sel_t edge_sel_r;
  logic irq_en_r;
  logic [1:0] mask_r;
  logic [1:0] st_r;
  logic [31:0] led_r;
  logic irq_r;
  logic stable0_d_r;

  logic aw_hs_w;
  logic w_hs_w;
  logic ar_hs_w;
  logic wr_go_w;
  logic b_done_w;
  logic r_done_w;
  logic wr_hit_w;
  logic wr_cfg_w;
  logic wr_stat_w;
  logic wr_mask_w;
  logic [7:0] wa8_w;
  logic [7:0] ra8_w;
  din_pkg::word_t cfg_word_w;
  din_pkg::word_t cfg_new_w;
  din_pkg::word_t mask_new_w;
  din_pkg::word_t clr_word_w;
  din_pkg::word_t rd_data_w;
  logic [1:0] st_set_w;
  logic [1:0] st_clr_w;
  logic [1:0] st_nxt;
  logic [1:0] mask_nxt;
  logic [CNT_W-1:0] limit_w;
  logic [31:0] stable_w;
  logic [31:0] filt_w;
  logic edge0_w;
  logic chg_w;

  ////////////////////////////////////////////////////////////////////////////
  // Input points

  // One filter time for the whole module
  assign limit_w = (filt_sel_r == din_pkg::FILT_10MS) ?
                   CNT_W'(LONG_CYCLES) : CNT_W'(SHORT_CYCLES);

  // Four groups of eight points, all on the shared limit
  for (genvar g = 0; g < 32; g++) begin : g_pt
    point_filter #(
      .CNT_W(CNT_W)
    ) u_pt (
      .clk_in(REF_CLK_IN),
      .rst_n_in(RST_N_IN),
      .raw_in(POINT_IN[g]),
      .limit_in(limit_w),
      .stable_out(stable_w[g]),
      .filt_out(filt_w[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events

  // Edge of point 0 taken from the synchronised level, ahead of the filter
  assign edge0_w = irq_en_r &&
                   ((edge_sel_r == din_pkg::EDGE_RISE) ?
                    (stable_w[0] && !stable0_d_r) :
                    (!stable_w[0] && stable0_d_r));
  // Any filtered point changed
  assign chg_w = |(filt_w ^ led_r);
  assign st_set_w = {chg_w, edge0_w};
  assign st_clr_w = wr_stat_w ? clr_word_w[1:0] : 2'h0;
  // A set in the clearing cycle survives
  assign st_nxt = (st_r & ~st_clr_w) | st_set_w;
  assign mask_nxt = wr_mask_w ? mask_new_w[1:0] : mask_r;

  ////////////////////////////////////////////////////////////////////////////
  // Write path decode

  assign aw_hs_w = AWVALID_IN && awready_r;
  assign w_hs_w = WVALID_IN && wready_r;
  assign wr_go_w = aw_ok_r && w_ok_r && !bvalid_r;
  assign b_done_w = bvalid_r && BREADY_IN;
  assign wa8_w = 8'(awaddr_r);
  assign wr_hit_w = addr_hit(awaddr_r);
  assign wr_cfg_w = wr_go_w && (wa8_w == `OFF_CFG);
  assign wr_stat_w = wr_go_w && (wa8_w == `OFF_STAT);
  assign wr_mask_w = wr_go_w && (wa8_w == `OFF_MASK);
  assign cfg_word_w = {29'h0, edge_sel_r, irq_en_r, filt_sel_r};
  assign cfg_new_w = byte_merge(cfg_word_w, wdata_r, wstrb_r);
  assign mask_new_w = byte_merge({30'h0, mask_r}, wdata_r, wstrb_r);
  assign clr_word_w = byte_merge(32'h0, wdata_r, wstrb_r);

  ////////////////////////////////////////////////////////////////////////////
  // Read path decode

  assign ar_hs_w = ARVALID_IN && arready_r;
  assign r_done_w = rvalid_r && RREADY_IN;
  assign ra8_w = 8'(ARADDR_IN);
  assign rd_data_w = (ra8_w == `OFF_POINT) ? filt_w :
                     (ra8_w == `OFF_CFG) ? cfg_word_w :
                     (ra8_w == `OFF_STAT) ? {30'h0, st_r} :
                     (ra8_w == `OFF_MASK) ? {30'h0, mask_r} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Write address and data capture, either order
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_hs_w) begin
        awready_r <= 1'b0;
        aw_ok_r <= 1'b1;
        awaddr_r <= AWADDR_IN;
      end
      if (w_hs_w) begin
        wready_r <= 1'b0;
        w_ok_r <= 1'b1;
        wdata_r <= WDATA_IN;
        wstrb_r <= WSTRB_IN;
      end
      if (wr_go_w) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
      end
      if (b_done_w) begin
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Write response, unmapped offsets answer SLVERR
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else if (wr_go_w) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit_w ? `RESP_OKAY : `RESP_SLVERR;
    end else if (b_done_w) begin
      bvalid_r <= 1'b0;
    end
  end

  // Read channel, one read at a time
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `RESP_OKAY;
    end else if (ar_hs_w) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_data_w;
      rresp_r <= addr_hit(ARADDR_IN) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (r_done_w) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      filt_sel_r <= din_pkg::filt_sel_t'(1'(`CFG_RST >> `CFG_LONG_BIT));
      irq_en_r <= 1'(`CFG_RST >> `CFG_IRQEN_BIT);
      edge_sel_r <= din_pkg::edge_sel_t'(1'(`CFG_RST >> `CFG_RISE_BIT));
    end else if (wr_cfg_w) begin
      filt_sel_r <= din_pkg::filt_sel_t'(cfg_new_w[`CFG_LONG_BIT]);
      irq_en_r <= cfg_new_w[`CFG_IRQEN_BIT];
      edge_sel_r <= din_pkg::edge_sel_t'(cfg_new_w[`CFG_RISE_BIT]);
    end
  end

  // Status, mask, indicators and interrupt line
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      st_r <= `STAT_RST;
      mask_r <= `MASK_RST;
      led_r <= 32'h0;
      irq_r <= 1'b0;
      stable0_d_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mask_r <= mask_nxt;
      led_r <= filt_w;
      irq_r <= |(st_nxt & mask_nxt);
      stable0_d_r <= stable_w[0];
    end
  end

  assign AWREADY_OUT = awready_r;
  assign WREADY_OUT = wready_r;
  assign BVALID_OUT = bvalid_r;
  assign BRESP_OUT = bresp_r;
  assign ARREADY_OUT = arready_r;
  assign RVALID_OUT = rvalid_r;
  assign RDATA_OUT = rdata_r;
  assign RRESP_OUT = rresp_r;
  assign LED_OUT = led_r;
  assign IRQ_OUT = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_point_read;
    ar_hs_w && (ra8_w == `OFF_POINT);
  endsequence

  sequence s_long_write;
    wr_cfg_w && cfg_new_w[`CFG_LONG_BIT];
  endsequence

  sequence s_glitch0;
    (stable_w[0] == filt_w[0]) ##1 (stable_w[0] != filt_w[0]) ##1
    (stable_w[0] == filt_w[0]);
  endsequence

  a_point_readback: assert property (
    s_point_read |=> RVALID_OUT && (RDATA_OUT == $past(filt_w)))
    else $error("point read does not return filtered state");

  a_limit_long: assert property (
    s_long_write |=> (limit_w == CNT_W'(LONG_CYCLES)) [*2])
    else $error("long filter time not applied");

  a_one_setting: assert property (
    (filt_sel_r == din_pkg::FILT_1MS) |-> (limit_w == CNT_W'(SHORT_CYCLES)))
    else $error("short filter time not shared");

  a_irq_src_point0: assert property (
    $rose(st_r[`ST_EDGE_BIT]) |->
      $past(irq_en_r) && ($past(stable_w[0]) != $past(stable0_d_r)))
    else $error("edge status set without point 0 edge");

  a_rise_sets_irq: assert property (
    (irq_en_r && edge_sel_r == din_pkg::EDGE_RISE && stable_w[0] &&
     !stable0_d_r) |=> st_r[`ST_EDGE_BIT])
    else $error("rising edge missed");

  a_irq_no_filter: assert property (
    (irq_en_r && edge_sel_r == din_pkg::EDGE_FALL && !stable_w[0] &&
     stable0_d_r && filt_sel_r == din_pkg::FILT_10MS) |=>
      st_r[`ST_EDGE_BIT] && $stable(filt_w[0]))
    else $error("falling edge delayed by filter");

  a_led_follows: assert property (
    $stable(filt_w) |-> (LED_OUT == filt_w))
    else $error("indicator differs from filtered state");

  a_filter_settle: assert property (
    $changed(filt_w[0]) |-> (filt_w[0] == $past(stable_w[0], 1)))
    else $error("filtered value moved to a wrong level");

  a_glitch_ignored: assert property (
    (limit_w > CNT_W'(2)) throughout s_glitch0 |-> $stable(filt_w[0]))
    else $error("short pulse passed the filter");

  a_irq_level: assert property (
    (|(st_r & mask_r)) |-> IRQ_OUT)
    else $error("interrupt low with unmasked status");

endmodule

//--- verification/cpu_model.sv
// Controller side model: AXI4-Lite master with blocking transfer tasks
`timescale 1ns/1ps

module cpu_model (
  input wire logic clk_in,
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic bvalid_in,
  output logic bready_out,
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  // Idle bus at time zero
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
  end

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output bit ok);
    ok = 1'b0;
    @(posedge clk_in);
    awaddr_out <= a;
    awvalid_out <= 1'b1;
    wdata_out <= d;
    wstrb_out <= 4'hf;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    for (int n = 0; n < 100 && !ok; n++) begin
      @(posedge clk_in);
      // Released payload toggles so nothing relies on a stale value
      if (awready_in && awvalid_out) begin
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (wready_in && wvalid_out) begin
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
      if (bvalid_in) begin
        bready_out <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask

  // Read: address held until taken, ready held until the data arrives
  task automatic rd(input logic [7:0] a, output bit ok);
    ok = 1'b0;
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    for (int n = 0; n < 100 && !ok; n++) begin
      @(posedge clk_in);
      if (arready_in && arvalid_out) begin
        arvalid_out <= 1'b0;
        araddr_out <= ~a;
      end
      if (rvalid_in) begin
        rready_out <= 1'b0;
        ok = 1'b1;
      end
    end
  endtask
endmodule

//--- verification/tb_filtered_input_port_with_edge_irq.sv
// Self-checking bench of the filtered input port with edge interrupt
`timescale 1ns/1ps
`include "din_consts.svh"

module tb_filtered_input_port_with_edge_irq;
  localparam int SHORT_L = 8;
  localparam int LONG_L = 20;
  logic clk = 1'b0;
  logic rst_n;
  logic [31:0] point, led, wdata, rdata, pat, cur;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [33:0] exp_q[$];
  logic [33:0] exp;
  int fails = 0;
  int compares = 0;
  int seed = 32'h0d0e2b5f;
  int lim;
  bit ok;

  always #12.5 clk = ~clk;

  din_top #(.SHORT_CYCLES(SHORT_L), .LONG_CYCLES(LONG_L)) i_dut (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .POINT_IN(point), .LED_OUT(led), .IRQ_OUT(irq),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .WDATA_IN(wdata),
    .WSTRB_IN(wstrb), .WVALID_IN(wvalid), .WREADY_OUT(wready), .BRESP_OUT(bresp),
    .BVALID_OUT(bvalid), .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
    .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
    .RREADY_IN(rready));

  cpu_model i_cpu (
    .clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
    .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready),
    .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
    .arready_in(arready), .rvalid_in(rvalid), .rready_out(rready));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_bus(input logic [33:0] got, input logic [33:0] want);
    compares++;
    if (got !== want) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  // Bus transfers note their expected answer first; a stuck bus ends the run
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    i_cpu.wr(a, d, ok);
    if (!ok) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    i_cpu.rd(a, ok);
    if (!ok) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic wait_led(input logic [31:0] v, input int bound);
    for (int n = 0; n < bound && led !== v; n++) @(posedge clk);
    chk_pin(led, v);
    if (led !== v) complete_run();
  endtask

  // Each bus answer takes the oldest expectation off the queue
  always @(posedge clk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      exp = exp_q.pop_front();
      chk_bus(rvalid ? {rresp, rdata} : {bresp, 32'h0}, exp);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    point = 32'h0;
    cur = 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_pin(led, 32'h0);
    chk_pin({31'h0, irq}, 32'h0);
    // Register reset values, access kinds and refused offsets
    rd(`OFF_CFG, {`RESP_OKAY, 32'h0});
    rd(`OFF_MASK, {`RESP_OKAY, 32'h0});
    wr(`OFF_CFG, 32'hffffffff, `RESP_OKAY);
    rd(`OFF_CFG, {`RESP_OKAY, 32'h7});
    wr(`OFF_MASK, 32'hffffffff, `RESP_OKAY);
    rd(`OFF_MASK, {`RESP_OKAY, 32'h3});
    wr(8'h10, 32'h1, `RESP_SLVERR);
    rd(8'h10, {`RESP_SLVERR, 32'h0});
    wr(`OFF_POINT, 32'hffffffff, `RESP_OKAY);
    rd(`OFF_POINT, {`RESP_OKAY, 32'h0});
    $display("register test done");
    // Both filter times: short pulse refused, held level shown after the delay
    for (int f = 0; f < 2; f++) begin
      lim = f ? LONG_L : SHORT_L;
      wr(`OFF_CFG, {31'h0, f[0]}, `RESP_OKAY);
      pat = $random(seed);
      point <= pat;
      repeat (lim - 1) @(posedge clk);
      point <= cur;
      repeat (lim + 10) @(posedge clk);
      chk_pin(led, cur);
      point <= pat;
      // Three sync stages, one agree cycle, the hold count, then the indicator flop
      repeat (lim + 5) @(posedge clk);
      chk_pin(led, cur);
      wait_led(pat, 1);
      rd(`OFF_POINT, {`RESP_OKAY, pat});
      // Change status set by the filtered change, mask is fully open here
      rd(`OFF_STAT, {`RESP_OKAY, 30'h0, pat != cur, 1'b0});
      chk_pin({31'h0, irq}, {31'h0, pat != cur});
      wr(`OFF_STAT, 32'h3, `RESP_OKAY);
      chk_pin({31'h0, irq}, 32'h0);
      cur = pat;
      $display("filter test %0d done", f);
    end
    // Edge interrupt on point 0 for each edge and filter time
    wr(`OFF_MASK, 32'h1, `RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      wr(`OFF_CFG, {29'h0, k[1], 1'b1, k[0]}, `RESP_OKAY);
      point[0] <= ~k[1];
      cur[0] = ~k[1];
      repeat (LONG_L + 10) @(posedge clk);
      chk_pin({31'h0, irq}, 32'h0);
      wr(`OFF_STAT, 32'h3, `RESP_OKAY);
      point[0] <= k[1];
      for (int n = 0; n < 8 && irq !== 1'b1; n++) @(posedge clk);
      chk_pin({31'h0, irq}, 32'h1);
      if (irq !== 1'b1) complete_run();
      chk_pin(led, cur);
      rd(`OFF_STAT, {`RESP_OKAY, 32'h1});
      wr(`OFF_STAT, 32'h1, `RESP_OKAY);
      chk_pin({31'h0, irq}, 32'h0);
      cur[0] = k[1];
      $display("interrupt test %0d done", k);
    end
    complete_run();
  end
endmodule
